// ==== verilog/lpt_tx.sv ====
// pixel capture, mode control and lane serializer of the display link transmitter
`default_nettype none

module lpt_tx (
  // clocks and reset
  input  wire logic                           clock_i,
  input  wire logic                           reset_i,
  input  wire logic                           link_clock_i,
  // parallel pixel input
  input  wire logic [lpt_pkg::CHAN_W-1:0]     red_i,
  input  wire logic [lpt_pkg::CHAN_W-1:0]     green_i,
  input  wire logic [lpt_pkg::CHAN_W-1:0]     blue_i,
  input  wire logic                           hsync_i,
  input  wire logic                           vsync_i,
  input  wire logic                           display_enable_i,
  // straps
  input  wire logic                           strobe_edge_select_i,
  input  wire logic                           enable_polarity_select_i,
  input  wire logic                           balance_mode_select_i,
  input  wire logic                           pixel_mode_dual_i,
  input  wire logic                           pixel_mode_mid_i,
  input  wire logic                           power_down_n_i,
  input  wire logic                           pll_range_select_i,
  // data lanes
  output logic      [lpt_pkg::LANE_N-1:0]     link_lane_p_o,
  output logic      [lpt_pkg::LANE_N-1:0]     link_lane_n_o,
  output logic      [lpt_pkg::LANE_N-1:0]     link_lane_oe_o,
  // link clocks
  output logic                                primary_link_clock_p_o,
  output logic                                primary_link_clock_n_o,
  output logic                                primary_link_clock_oe_o,
  output logic                                secondary_link_clock_p_o,
  output logic                                secondary_link_clock_n_o,
  output logic                                secondary_link_clock_oe_o,
  // status
  output logic                                capture_ready_o,
  output logic                                pll_range_high_o
);

  localparam int W = lpt_pkg::WORD_W;
  localparam int L = lpt_pkg::LANE_N;

  // ==========================================================================
  // state of the pixel domain
  typedef struct packed {
    logic [lpt_pkg::CAP_W-1:0]  rise;       // rising edge sample
    logic [W-1:0]               wr_data;
    logic                       wr_valid;
    logic                       half;       // first pixel of a pair held
    logic [lpt_pkg::PIX_W-1:0]  held;
    logic                       tog_prev;
    logic [15:0]                win_cnt;
    logic                       range_high;
  } lpt_pix_s;

  // state of the link domain
  typedef struct packed {
    logic [2:0]                 slot;
    logic [W-1:0]               cur;
    logic [L-1:0]               lane_bit;
    logic [L-1:0]               lane_oe;
    logic                       clk_bit;
    logic                       clk_oe;
    logic [L-1:0][4:0]          disp;       // running disparity per lane
    logic [7:0]                 div;
    logic                       tog;
  } lpt_link_s;

  lpt_pix_s  px_r, px_nxt;
  lpt_link_s lk_r, lk_nxt;
  logic [lpt_pkg::CAP_W-1:0] fall_q;
  logic [lpt_pkg::CAP_W-1:0] pins;
  logic [5:0] pstrap;
  logic [3:0] lstrap;
  logic       link_reset;
  logic       tog_sync;

  lpt_fifo_if #(.WIDTH(W)) fifo_if ();

  // ==========================================================================
  // crossings and buffer
  // straps read low
  lpt_sync #(.W(6)) u_pix_strap (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .d_i     ({pll_range_select_i, strobe_edge_select_i, enable_polarity_select_i,
               balance_mode_select_i, pixel_mode_dual_i, pixel_mode_mid_i}),
    .q_o     (pstrap)
  );

  // reset is carried into the link domain as a level
  lpt_sync #(.W(1)) u_link_rst (
    .clock_i (link_clock_i),
    .reset_i (1'b0),
    .d_i     (reset_i),
    .q_o     (link_reset)
  );

  lpt_sync #(.W(4)) u_link_strap (
    .clock_i (link_clock_i),
    .reset_i (link_reset),
    .d_i     ({power_down_n_i, balance_mode_select_i, pixel_mode_dual_i, pixel_mode_mid_i}),
    .q_o     (lstrap)
  );

  // window toggle from the link domain, used as the frequency yardstick
  lpt_sync #(.W(1)) u_tog (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .d_i     (lk_r.tog),
    .q_o     (tog_sync)
  );

  lpt_fifo #(.WIDTH(W), .DEPTH(lpt_pkg::FIFO_DEPTH)) u_fifo (
    .wr_clock_i (clock_i),
    .wr_reset_i (reset_i),
    .rd_clock_i (link_clock_i),
    .rd_reset_i (link_reset),
    .port       (fifo_if.buffer)
  );

  // ==========================================================================
  // pixel capture
  // all 51 inputs taken together
  assign pins = {display_enable_i, vsync_i, hsync_i, blue_i, green_i, red_i};

  always_ff @(negedge clock_i) begin
    fall_q <= pins;
  end

  // build one link word; balanced lanes carry six payload bits and a flag slot
  function automatic logic [W-1:0] pack_word(input logic balance_mode_select, input logic active,
                                             input logic [2:0] ctl,
                                             input logic [lpt_pkg::PIX_W-1:0] a,
                                             input logic [lpt_pkg::PIX_W-1:0] b);
    logic [W-1:0]  w;
    logic [47:0]   pay;
    w   = '0;
    pay = active ? {b, a} : {45'h0000_0000_0000, ctl};
    if (balance_mode_select) begin
      for (int l = 0; l < L; l++) begin
        w[l*lpt_pkg::SLOT_N +: lpt_pkg::PAYLOAD_W] = pay[l*lpt_pkg::PAYLOAD_W +: 6];
      end
    end else begin
      w[lpt_pkg::POS_A +: lpt_pkg::PIX_W] = a;
      w[lpt_pkg::POS_HS]                  = ctl[0];
      w[lpt_pkg::POS_VS]                  = ctl[1];
      w[lpt_pkg::POS_DE]                  = ctl[2];
      w[lpt_pkg::POS_B +: lpt_pkg::PIX_W] = b;
    end
    return w;
  endfunction

  // pixel domain next state
  always_comb begin
    logic [lpt_pkg::CAP_W-1:0]  s;
    logic [lpt_pkg::PIX_W-1:0]  pa, pb;
    logic                       act, balance_mode_select, take, tog_edge;
    logic [2:0]                 ctl;
    lpt_pkg::lpt_mode_e         mode;
    logic [W-1:0]               word;
    logic                       emit;
    px_nxt   = px_r;
    px_nxt.rise = pins;
    s        = pstrap[4] ? px_r.rise : fall_q;
    pa       = {s[7:0], s[23:16], s[39:32]};
    pb       = {s[15:8], s[31:24], s[47:40]};
    act      = pstrap[3] ? s[50] : !s[50];
    ctl      = {act, s[49], s[48]};
    balance_mode_select      = pstrap[2];
    mode     = lpt_pkg::lpt_mode_decode(pstrap[1], pstrap[0]);
    word     = '0;
    emit     = 1'b0;
    unique case (mode)
      lpt_pkg::MODE_SINGLE: begin
        word = pack_word(balance_mode_select, act, ctl, pa, '0);
        emit = 1'b1;
      end
      lpt_pkg::MODE_DUAL: begin
        word = pack_word(balance_mode_select, act, ctl, pa, pb);
        emit = 1'b1;
      end
      lpt_pkg::MODE_SIDO: begin
        px_nxt.half = !px_r.half;
        if (!px_r.half) begin
          px_nxt.held = pa;
        end else begin
          word = pack_word(balance_mode_select, act, ctl, px_r.held, pa);
          emit = 1'b1;
        end
      end
    endcase
    if (mode != lpt_pkg::MODE_SIDO) begin
      px_nxt.half = 1'b0;
    end
    // a word waiting on a full buffer is kept; newer pixels are dropped
    take = !px_r.wr_valid || fifo_if.wr_ready;
    if (take) begin
      px_nxt.wr_valid = emit;
      px_nxt.wr_data  = word;
    end
    // count pixel cycles per link window, switch with hysteresis
    tog_edge        = tog_sync ^ px_r.tog_prev;
    px_nxt.tog_prev = tog_sync;
    if (tog_edge) begin
      px_nxt.win_cnt = lpt_pkg::RANGE_CNT_RST;
      if (!pstrap[5]) begin
        px_nxt.range_high = 1'b0;
      end else if (px_r.win_cnt >= lpt_pkg::RANGE_UP_CNT) begin
        px_nxt.range_high = 1'b1;
      end else if (px_r.win_cnt <= lpt_pkg::RANGE_DN_CNT) begin
        px_nxt.range_high = 1'b0;
      end
    end else if (px_r.win_cnt != 16'hFFFF) begin
      px_nxt.win_cnt = px_r.win_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      px_r <= '0;
    end else begin
      px_r <= px_nxt;
    end
  end

  assign fifo_if.wr_valid = px_r.wr_valid;
  assign fifo_if.wr_data  = px_r.wr_data;
  assign capture_ready_o  = fifo_if.wr_ready;
  assign pll_range_high_o = px_r.range_high;

  // ==========================================================================
  // link serializer
  // dc balance: flip a lane's payload when it would grow a nonzero running disparity
  always_comb begin
    logic [W-1:0]       nw;
    logic [2:0]         nslot;
    logic [5:0]         pay;
    logic signed [4:0]  diff, d;
    logic [2:0]         ones;
    logic               single;
    pay         = '0;
    ones        = '0;
    diff        = '0;
    d           = '0;
    lk_nxt      = lk_r;
    nw          = lk_r.cur;
    single      = (lpt_pkg::lpt_mode_decode(lstrap[1], lstrap[0]) == lpt_pkg::MODE_SINGLE);
    nslot       = (lk_r.slot == lpt_pkg::SLOT_LAST) ? lpt_pkg::SLOT_RST : lk_r.slot + 3'h1;
    lk_nxt.slot = nslot;
    lk_nxt.div  = lk_r.div + 8'h01;
    if (lk_r.div == 8'hFF) begin
      lk_nxt.tog = !lk_r.tog;
    end
    if (lk_r.slot == lpt_pkg::SLOT_LAST) begin
      nw = fifo_if.rd_valid ? fifo_if.rd_data : '0;
      if (lstrap[2]) begin
        for (int l = 0; l < L; l++) begin
          pay  = nw[l*lpt_pkg::SLOT_N +: 6];
          ones = 3'($countones(pay));
          diff = 5'(signed'({2'b00, ones}) * 2 - 6);
          d    = signed'(lk_r.disp[l]);
          if ((diff != 0) && (d != 0) && (diff[4] == d[4])) begin
            nw[l*lpt_pkg::SLOT_N +: 7] = {1'b1, ~pay};
            lk_nxt.disp[l]             = 5'(d - diff);
          end else begin
            nw[l*lpt_pkg::SLOT_N +: 7] = {1'b0, pay};
            lk_nxt.disp[l]             = 5'(d + diff);
          end
        end
      end
      lk_nxt.cur = nw;
    end
    // registered outputs, msb of each lane first
    for (int l = 0; l < L; l++) begin
      lk_nxt.lane_bit[l] = nw[l*lpt_pkg::SLOT_N + int'(lpt_pkg::SLOT_LAST - nslot)];
      // power down or idle upper lanes release the lane
      lk_nxt.lane_oe[l]  = lstrap[3] && !(single && (l >= lpt_pkg::LANE_SINGLE_N));
      if (!lk_nxt.lane_oe[l]) begin
        lk_nxt.lane_bit[l] = 1'b0;
      end
    end
    lk_nxt.clk_oe  = lstrap[3];
    lk_nxt.clk_bit = lstrap[3] && lpt_pkg::CLK_PATTERN[lpt_pkg::SLOT_LAST - nslot];
  end

  always_ff @(posedge link_clock_i) begin
    if (link_reset) begin
      lk_r <= '0;
    end else begin
      lk_r <= lk_nxt;
    end
  end

  // words are taken only at a word boundary
  assign fifo_if.rd_ready = (lk_r.slot == lpt_pkg::SLOT_LAST);

  // ==========================================================================
  // pins: complementary legs gated by the enables
  assign link_lane_p_o  = lk_r.lane_bit;
  assign link_lane_n_o  = ~lk_r.lane_bit & lk_r.lane_oe;
  assign link_lane_oe_o = lk_r.lane_oe;
  assign primary_link_clock_p_o  = lk_r.clk_bit;
  assign primary_link_clock_n_o  = !lk_r.clk_bit && lk_r.clk_oe;
  assign primary_link_clock_oe_o = lk_r.clk_oe;
  assign secondary_link_clock_p_o  = lk_r.clk_bit;
  assign secondary_link_clock_n_o  = !lk_r.clk_bit && lk_r.clk_oe;
  assign secondary_link_clock_oe_o = lk_r.clk_oe;

endmodule // lpt_tx

`default_nettype wire

// ==== verilog/lpt_pkg.sv ====
// constants, types and helpers shared by the pixel link transmitter files
`default_nettype none

package lpt_pkg;

  // ==========================================================================
  // widths and word layout
  localparam int CHAN_W        = 16;   // bits per colour channel on the input
  localparam int PIX_W         = 24;   // one single-mode pixel
  localparam int CAP_W         = 51;   // 48 colour bits plus three controls
  localparam int LANE_N        = 8;    // data lanes in dual mode
  localparam int LANE_SINGLE_N = 4;    // data lanes in single mode
  localparam int SLOT_N        = 7;    // serial bits per lane per link word
  localparam int PAYLOAD_W     = 6;    // payload bits per lane when balanced
  localparam int WORD_W        = 56;   // one link word, all lanes
  localparam int FIFO_DEPTH    = 32;

  // plain layout: pixel a, controls, pixel b
  localparam int POS_A  = 0;
  localparam int POS_HS = 24;
  localparam int POS_VS = 25;
  localparam int POS_DE = 26;
  localparam int POS_B  = 28;

  // ==========================================================================
  // link timing
  localparam logic [6:0] CLK_PATTERN = 7'h63;   // link clock shape over one word
  localparam logic [2:0] SLOT_LAST   = 3'h6;
  localparam logic [2:0] SLOT_RST    = 3'h0;
  localparam logic [4:0] DISP_RST    = 5'h00;

  // ==========================================================================
  // clock multiplier range switch, measured against the link clock
  localparam int LINK_PERIOD_NS = 48;
  localparam int RANGE_LO_MHZ   = 55;
  localparam int RANGE_HI_MHZ   = 68;
  localparam int REF_DIV_LOG2   = 8;    // window of 256 link cycles
  localparam logic [7:0]  REF_DIV_RST = 8'h00;
  // pixel cycles seen in one window at the switch frequencies
  localparam logic [15:0] RANGE_UP_CNT =
    16'(RANGE_HI_MHZ * (1 << REF_DIV_LOG2) * LINK_PERIOD_NS / 1000);
  localparam logic [15:0] RANGE_DN_CNT =
    16'(RANGE_LO_MHZ * (1 << REF_DIV_LOG2) * LINK_PERIOD_NS / 1000);
  localparam logic [15:0] RANGE_CNT_RST = 16'h0000;

  // ==========================================================================
  // pixel modes, gray coded
  typedef enum logic [1:0] {
    MODE_SINGLE = 2'h0,
    MODE_DUAL   = 2'h1,
    MODE_SIDO   = 2'h3
  } lpt_mode_e;

  // three-level strap arrives as two comparator outputs; mid level wins
  function automatic lpt_mode_e lpt_mode_decode(input logic dual, input logic mid);
    if (mid) begin
      return MODE_SIDO;
    end
    return dual ? MODE_DUAL : MODE_SINGLE;
  endfunction

endpackage

`default_nettype wire

// ==== verilog/lpt_fifo_if.sv ====
// valid/ready carrier between the capture logic and the link buffer
`default_nettype none

interface lpt_fifo_if #(
  parameter int WIDTH = 56
);
  logic             wr_valid;
  logic             wr_ready;
  logic [WIDTH-1:0] wr_data;
  logic             rd_valid;
  logic             rd_ready;
  logic [WIDTH-1:0] rd_data;

  modport producer (output wr_valid, output wr_data, input wr_ready);
  modport consumer (input rd_valid, input rd_data, output rd_ready);
  modport buffer (input wr_valid, input wr_data, output wr_ready,
                  output rd_valid, output rd_data, input rd_ready);
endinterface

`default_nettype wire

// ==== verilog/lpt_sync.sv ====
// two flip-flop level synchroniser
`default_nettype none

module lpt_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input  wire logic         clock_i,
  input  wire logic         reset_i,
  // level in, level out
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } lpt_sync_s;

  lpt_sync_s st_r;
  lpt_sync_s st_nxt;

  // ==========================================================================
  // next state: first stage feeds only the second
  always_comb begin
    st_nxt    = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  // open straps read as low until the first samples arrive
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;

endmodule // lpt_sync

`default_nettype wire

// ==== verilog/lpt_fifo.sv ====
// dual-clock word buffer with gray coded pointers
`default_nettype none

module lpt_fifo #(
  parameter int WIDTH = 56,
  parameter int DEPTH = 32
) (
  // write side clock and reset
  input  wire logic   wr_clock_i,
  input  wire logic   wr_reset_i,
  // read side clock and reset
  input  wire logic   rd_clock_i,
  input  wire logic   rd_reset_i,
  // both handshakes
  lpt_fifo_if.buffer  port
);

  localparam int AW = $clog2(DEPTH);

  if ((DEPTH < 4) || ((DEPTH & (DEPTH - 1)) != 0)) begin : g_bad_depth
    $error("lpt_fifo depth must be a power of two, at least 4");
  end

  typedef struct packed {
    logic [AW:0] bin;
    logic [AW:0] gray;
    logic [AW:0] far1;   // other side's gray pointer, first stage
    logic [AW:0] far2;
  } lpt_ptr_s;

  logic [WIDTH-1:0] mem [DEPTH];
  lpt_ptr_s wr_r, wr_nxt, rd_r, rd_nxt;
  logic full, empty, push, pop;

  function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
    return b ^ (b >> 1);
  endfunction

  // ==========================================================================
  // status: full when the top two gray bits differ and the rest match
  assign full  = (wr_r.gray == {~wr_r.far2[AW:AW-1], wr_r.far2[AW-2:0]});
  assign empty = (rd_r.gray == rd_r.far2);
  assign push  = port.wr_valid && port.wr_ready;
  assign pop   = port.rd_valid && port.rd_ready;
  assign port.wr_ready = !full;
  assign port.rd_valid = !empty;
  assign port.rd_data  = mem[rd_r.bin[AW-1:0]];

  // write side pointer and far copy of the read pointer
  always_comb begin
    wr_nxt      = wr_r;
    wr_nxt.far1 = rd_r.gray;
    wr_nxt.far2 = wr_r.far1;
    if (push) begin
      wr_nxt.bin  = wr_r.bin + 1'b1;
      wr_nxt.gray = bin2gray(wr_nxt.bin);
    end
  end

  // read side pointer and far copy of the write pointer
  always_comb begin
    rd_nxt      = rd_r;
    rd_nxt.far1 = wr_r.gray;
    rd_nxt.far2 = rd_r.far1;
    if (pop) begin
      rd_nxt.bin  = rd_r.bin + 1'b1;
      rd_nxt.gray = bin2gray(rd_nxt.bin);
    end
  end

  always_ff @(posedge wr_clock_i) begin
    if (wr_reset_i) begin
      wr_r <= '0;
    end else begin
      wr_r <= wr_nxt;
    end
  end

  // storage has no reset; empty hides stale words
  always_ff @(posedge wr_clock_i) begin
    if (push) begin
      mem[wr_r.bin[AW-1:0]] <= port.wr_data;
    end
  end

  always_ff @(posedge rd_clock_i) begin
    if (rd_reset_i) begin
      rd_r <= '0;
    end else begin
      rd_r <= rd_nxt;
    end
  end

endmodule // lpt_fifo

`default_nettype wire

// ==== tb/lpt_tx_checker.sv ====
// assertions on the link pins of the pixel link transmitter
`default_nettype none

module lpt_tx_checker (
  // clock and reset
  input  wire logic       link_clock_i,
  input  wire logic       reset_i,
  // straps
  input  wire logic       pixel_mode_dual_i,
  input  wire logic       pixel_mode_mid_i,
  input  wire logic       power_down_n_i,
  // link pins
  input  wire logic [7:0] link_lane_p_o,
  input  wire logic [7:0] link_lane_n_o,
  input  wire logic [7:0] link_lane_oe_o,
  input  wire logic       primary_link_clock_p_o,
  input  wire logic       primary_link_clock_n_o,
  input  wire logic       primary_link_clock_oe_o,
  input  wire logic       secondary_link_clock_p_o,
  input  wire logic       secondary_link_clock_n_o,
  input  wire logic       secondary_link_clock_oe_o
);
  // ==========================================================================
  // strap history: straps cross syncs and a register stage, so allow 16
  wire logic   on_w = !reset_i && power_down_n_i;
  logic [15:0] off_r;
  logic [15:0] one_r;
  logic [15:0] two_r;
  always_ff @(posedge link_clock_i) begin
    off_r <= {off_r[14:0], !power_down_n_i};
    one_r <= {one_r[14:0], on_w && !pixel_mode_dual_i && !pixel_mode_mid_i};
    two_r <= {two_r[14:0], on_w && (pixel_mode_dual_i || pixel_mode_mid_i)};
  end

  default clocking @(posedge link_clock_i); endclocking
  default disable iff (reset_i);

  // ==========================================================================
  // link pin relations
  AST_PD_OFF: assert property (&off_r |-> !link_lane_oe_o && !primary_link_clock_oe_o)
    else $error("link outputs enabled in power down");
  AST_PD_LEGS: assert property (&off_r |-> (link_lane_p_o | link_lane_n_o) == 8'h00)
    else $error("link legs not low in power down");
  AST_LEGS: assert property ((link_lane_p_o ^ link_lane_n_o) == link_lane_oe_o)
    else $error("lane legs not complementary while driven");
  AST_ONE_IDLE: assert property (&one_r |-> link_lane_oe_o[7:4] == 4'h0)
    else $error("upper lanes driven in single mode");
  AST_ONE_ON: assert property (&one_r |-> link_lane_oe_o[3:0] == 4'hF && primary_link_clock_oe_o)
    else $error("lower lanes or clock idle in single mode");
  AST_TWO_ON: assert property (&two_r |-> link_lane_oe_o == 8'hFF)
    else $error("lane idle in dual output mode");
  AST_COPY: assert property ({secondary_link_clock_p_o, secondary_link_clock_n_o,
      secondary_link_clock_oe_o} == {primary_link_clock_p_o, primary_link_clock_n_o,
      primary_link_clock_oe_o})
    else $error("secondary clock differs from primary");
  // a word shows clock slots 1,1,0,0,0,1,1, so low runs 3 and high runs 4
  property clk_shape_p;
    @(posedge link_clock_i) disable iff (reset_i || !primary_link_clock_oe_o)
      $fell(primary_link_clock_p_o) |->
        !primary_link_clock_p_o [*3] ##1 primary_link_clock_p_o [*4];
  endproperty
  AST_CLK_SHAPE: assert property (clk_shape_p)
    else $error("link clock shape wrong");

  COV_ONE: cover property (&one_r);
  COV_TWO: cover property (&two_r);
  COV_OFF: cover property (&off_r);
endmodule // lpt_tx_checker

bind lpt_tx lpt_tx_checker i_lpt_tx_checker (.*);

`default_nettype wire

// ==== tb/lpt_rx_model.sv ====
// receiver-side model that frames link words from the lane pins
`default_nettype none

module lpt_rx_model (
  // link pins
  input  wire logic        link_clock_i,
  input  wire logic [7:0]  lane_i,
  input  wire logic        clk_p_i,
  // framed word and its one-cycle strobe
  output logic      [55:0] word_o,
  output logic             strobe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [6:0]  clk_h;
  logic [55:0] sh;
  // framed by clock shape
  // slot 6 arrives first; a full clock shape marks the last slot of a word
  always @(posedge link_clock_i) begin
    clk_h = {clk_h[5:0], clk_p_i};
    for (int l = 0; l < 8; l++) begin
      sh[l*7 +: 7] = {sh[l*7 +: 6], lane_i[l]};
    end
    strobe_o <= (clk_h == 7'h63);
    word_o   <= sh;
  end
endmodule // lpt_rx_model

`default_nettype wire

// ==== tb/testbench.sv ====
// self-checking bench of the pixel link transmitter
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pins; every input has a value at time zero
  logic        clock_i = 1'b0;
  logic        link_clock_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [15:0] red_i = 16'h0000, green_i = 16'h0000, blue_i = 16'h0000;
  logic        hsync_i = 1'b0, vsync_i = 1'b0, display_enable_i = 1'b0;
  logic        strobe_edge_select_i = 1'b1, enable_polarity_select_i = 1'b1;
  logic        balance_mode_select_i = 1'b0, power_down_n_i = 1'b1;
  logic        pixel_mode_dual_i = 1'b1, pixel_mode_mid_i = 1'b0;
  logic        pll_range_select_i = 1'b1;
  logic [7:0]  link_lane_p_o, link_lane_n_o, link_lane_oe_o;
  logic        primary_link_clock_p_o, primary_link_clock_n_o, primary_link_clock_oe_o;
  logic        secondary_link_clock_p_o, secondary_link_clock_n_o, secondary_link_clock_oe_o;
  logic        capture_ready_o, pll_range_high_o, rx_strobe;
  logic [55:0] rx_word, exp_w;
  logic [31:0] seed = 32'h0000_E63D;
  int          mismatches = 0, cmp_count = 0, half = 10, i;

  // half period is a variable so the pixel rate can be moved or halted
  always #half clock_i = ~clock_i;
  initial begin
    #7;
    forever #24 link_clock_i = ~link_clock_i;
  end

  lpt_tx i_lpt_tx (.*);
  lpt_rx_model i_lpt_rx_model (.link_clock_i, .lane_i(link_lane_p_o),
    .clk_p_i(primary_link_clock_p_o), .word_o(rx_word), .strobe_o(rx_strobe));

  // ==========================================================================
  // helpers and reference model
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  // plain word: pixel a, hs, vs, active, pixel b; single mode carries no b
  function automatic logic [55:0] plain(input logic [7:0] a, b, input logic hs, vs, act, one);
    logic [55:0] w;
    w = '0;
    w[26:0] = {act, vs, hs, {3{a}}};
    if (!one) w[51:28] = {3{b}};
    return w;
  endfunction

  task automatic end_sim;
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [55:0] seen, input logic [55:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // bounded wait for framed words; old words leave the buffer meanwhile
  task automatic next_word(input int n);
    int guard;
    guard = 0;
    while (n > 0) begin
      @(posedge link_clock_i);
      if (rx_strobe === 1'b1) n--;
      guard++;
      if (guard > 30000) begin
        mismatches++;
        end_sim();
      end
    end
  endtask

  // inputs move on the falling edge by non-blocking assignment
  task automatic drive(input logic [31:0] s, input int m, input logic balance_mode_select);
    @(negedge clock_i);
    red_i <= {s[23:16], s[7:0]};
    green_i <= {s[23:16], s[7:0]};
    blue_i <= {s[23:16], s[7:0]};
    {vsync_i, hsync_i, display_enable_i} <= s[12:10];
    {enable_polarity_select_i, strobe_edge_select_i} <= s[9:8];
    pixel_mode_dual_i <= (m == 1);
    pixel_mode_mid_i <= (m == 2);
    balance_mode_select_i <= balance_mode_select;
  endtask

  task automatic range(input int h, input logic e);
    half = h;
    repeat (800) @(posedge link_clock_i);
    check(56'(pll_range_high_o), 56'(e));
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(negedge clock_i);
    reset_i <= 1'b0;
    next_word(4);
    // 50 MHz stays low, 71 MHz switches up, back to 50 MHz switches down
    range(10, 1'b0);
    range(7, 1'b1);
    range(10, 1'b0);
    for (int k = 0; k < 12; k++) begin
      seed = xorshift(seed);
      drive(seed, k % 3, 1'b0);
      next_word(45);
      exp_w = plain(seed[7:0], (k % 3 == 2) ? seed[7:0] : seed[23:16], seed[11],
                    seed[12], seed[10] ~^ seed[9], k % 3 == 0);
      check(rx_word & ((k % 3 == 0) ? 56'h00_0000_0FFF_FFFF : '1), exp_w);
    end
    @(negedge clock_i);
    power_down_n_i <= 1'b0;
    repeat (20) @(posedge link_clock_i);
    check({link_lane_oe_o, primary_link_clock_oe_o}, 56'h0);
    @(negedge clock_i);
    power_down_n_i <= 1'b1;
    // pixels outrun the link, so the buffer must refuse at some point
    i = 0;
    while (capture_ready_o !== 1'b0 && i < 2000) begin
      @(negedge clock_i);
      i++;
    end
    check(56'(capture_ready_o), 56'h0);
    // halt the pixel clock: the buffer drains and empty words follow
    half = 50000;
    next_word(40);
    check(rx_word, 56'h0);
    half = 10;
    drive(32'hFFFF_FFFF, 1, 1'b1);
    next_word(45);
    // balanced lanes carry an invert flag over six payload bits
    for (int l = 0; l < 8; l++) begin
      exp_w[5:0] = rx_word[l*7+6] ? ~rx_word[l*7 +: 6] : rx_word[l*7 +: 6];
      check(56'(exp_w[5:0]), 56'h3F);
    end
    end_sim();
  end
endmodule // testbench

`default_nettype wire
